// ---- logic/pic_interval_clock.sv ----
// Programmable interval clock with an Avalon-MM register slave
`timescale 1ns/1ps
`include "pic_regs.svh"


module pic_interval_clock
    import pic_pkg::*;
#(
    parameter int CNT_W       = 16,
    parameter int ADDR_W      = 4,
    parameter int BASE_CYCLES = `PIC_BASE_CYCLES,
    parameter int SLOW_DIV    = `PIC_SLOW_DIV
) (
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              lineIn,
    input  wire logic              extIn,
    output logic                   intReq,
    input  wire logic              intGrant
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pic_bus_st_t      busSt_r;
    pic_bus_st_t      busSt_nxt;
    pic_csr_t         csr_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] buf_r;
    logic [CNT_W-1:0] cntStep;
    logic [31:0]      rdData_nxt;
    logic             busReq;
    logic             busAck;
    logic             wrCsr;
    logic             wrBuf;
    logic             srcTick;
    logic             maintPulse;
    logic             step;
    logic             wrap;
    logic             dirDown;
    logic             errSet;
    logic             doneClr;
    logic             errClr;
    logic             intSet;

    // Word index decode, low byte-select bits ignored
    function automatic logic isReg(input logic [ADDR_W-1:0] a, input logic [1:0] idx);
        return a[ADDR_W-1:2] == (ADDR_W-2)'(idx);
    endfunction

    // ------------------------------------------------------------
    // Count source
    // ------------------------------------------------------------
    pic_src_sel #(
        .BASE_CYCLES (BASE_CYCLES),
        .SLOW_DIV    (SLOW_DIV)
    ) u_src (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .rate    (csr_r.rate),
        .lineIn  (lineIn),
        .extIn   (extIn),
        .srcTick (srcTick)
    );

    // ------------------------------------------------------------
    // Bus slave: one wait cycle, then the answer
    // ------------------------------------------------------------
    assign busReq          = avs_read | avs_write;
    assign avs_waitrequest = busReq & (busSt_r != PIC_BUS_ACK);
    assign busAck          = busReq & (busSt_r == PIC_BUS_ACK);
    assign wrCsr           = busAck & avs_write & isReg(avs_address, `PIC_IDX_CSR);
    assign wrBuf           = busAck & avs_write & isReg(avs_address, `PIC_IDX_BUF);

    always_comb begin
        busSt_nxt = PIC_BUS_IDLE;
        unique case (busSt_r)
            PIC_BUS_IDLE: begin
                if (busReq) begin
                    busSt_nxt = PIC_BUS_ACK;
                end
            end
            PIC_BUS_ACK: begin
                busSt_nxt = PIC_BUS_IDLE;
            end
            default: begin
                busSt_nxt = PIC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            busSt_r <= PIC_BUS_IDLE;
        end else begin
            busSt_r <= busSt_nxt;
        end
    end

    // Read mux; holding register and unmapped words read as zero
    always_comb begin
        rdData_nxt = 32'h0000_0000;
        if (isReg(avs_address, `PIC_IDX_CSR)) begin
            rdData_nxt[8:0] = csr_r;
        end else if (isReg(avs_address, `PIC_IDX_CNT)) begin
            rdData_nxt[CNT_W-1:0] = cnt_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (busSt_r == PIC_BUS_IDLE && avs_read) begin
            avs_readdata <= rdData_nxt;
        end
    end

    // ------------------------------------------------------------
    // Control/status word
    // ------------------------------------------------------------
    assign maintPulse = wrCsr & avs_writedata[`PIC_B_MAINT];
    assign doneClr    = wrCsr & avs_writedata[`PIC_B_DONE];
    assign errClr     = wrCsr & avs_writedata[`PIC_B_ERR];

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            csr_r.rate       <= PIC_RATE_100K;
            csr_r.repeatMode <= 1'b0;
            csr_r.countDown  <= 1'b0;
            csr_r.intEn      <= 1'b0;
        end else if (wrCsr) begin
            csr_r.rate       <= pic_rate_t'(avs_writedata[`PIC_B_RATE_HI:`PIC_B_RATE_LO]);
            csr_r.repeatMode <= avs_writedata[`PIC_B_REPEAT];
            csr_r.countDown  <= avs_writedata[`PIC_B_DOWN];
            csr_r.intEn      <= avs_writedata[`PIC_B_INTEN];
        end
    end

    // Maintenance step is a pulse and always reads back as zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            csr_r.maint <= 1'b0;
        end else begin
            csr_r.maint <= 1'b0;
        end
    end

    // Host write wins over the single-mode stop
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            csr_r.run <= 1'b0;
        end else if (wrCsr) begin
            csr_r.run <= avs_writedata[`PIC_B_RUN];
        end else if (wrap && !csr_r.repeatMode) begin
            csr_r.run <= 1'b0;
        end
    end

    // Flags: written one clears, a new event in the same cycle wins
    assign errSet = wrap & csr_r.repeatMode & csr_r.doneFlag;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            csr_r.doneFlag <= 1'b0;
        end else begin
            csr_r.doneFlag <= wrap | (csr_r.doneFlag & ~doneClr);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            csr_r.errFlag <= 1'b0;
        end else begin
            csr_r.errFlag <= errSet | (csr_r.errFlag & ~errClr);
        end
    end

    // ------------------------------------------------------------
    // Holding register and counter
    // ------------------------------------------------------------
    // Direction written together with a step applies to that step
    assign dirDown = wrCsr ? avs_writedata[`PIC_B_DOWN] : csr_r.countDown;
    assign step    = (csr_r.run & srcTick) | maintPulse;
    assign cntStep = dirDown ? cnt_r - CNT_W'(1) : cnt_r + CNT_W'(1);
    assign wrap    = step & (cntStep == '0);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            buf_r <= CNT_W'(`PIC_CNT_RST);
        end else if (wrBuf) begin
            buf_r <= avs_writedata[CNT_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_r <= CNT_W'(`PIC_CNT_RST);
        end else if (wrBuf) begin
            cnt_r <= avs_writedata[CNT_W-1:0];
        end else if (wrap && csr_r.repeatMode) begin
            cnt_r <= buf_r;
        end else if (wrap) begin
            cnt_r <= '0;
        end else if (step) begin
            cnt_r <= cntStep;
        end
    end

    // ------------------------------------------------------------
    // Interrupt request to the bus arbiter
    // ------------------------------------------------------------
    assign intSet = wrap & csr_r.intEn;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            intReq <= 1'b0;
        end else begin
            intReq <= intSet | (intReq & ~intGrant & csr_r.intEn);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_answer;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence

    sequence s_wrapSingle;
        wrap && !csr_r.repeatMode && !wrBuf && !wrCsr;
    endsequence

    property p_busAnswer;
        (busReq && busSt_r == PIC_BUS_IDLE) |-> s_answer;
    endproperty
    a_busAnswer: assert property (p_busAnswer) else $error("bus answer not after one wait");

    property p_cntRead;
        (avs_read && busSt_r == PIC_BUS_IDLE && isReg(avs_address, `PIC_IDX_CNT))
            |=> avs_readdata[CNT_W-1:0] == $past(cnt_r);
    endproperty
    a_cntRead: assert property (p_cntRead) else $error("counter read wrong value");

    property p_countDown;
        (step && dirDown && !wrap && !wrBuf) |=> cnt_r == CNT_W'($past(cnt_r) - 1);
    endproperty
    a_countDown: assert property (p_countDown) else $error("down step wrong");

    property p_underflow;
        (step && dirDown && cnt_r == CNT_W'(1)) |-> wrap;
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow missed");

    property p_overflow;
        (step && !dirDown && cnt_r == '1) |-> wrap;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow missed");

    property p_bufLoad;
        wrBuf |=> (cnt_r == CNT_W'($past(avs_writedata))) && (buf_r == cnt_r);
    endproperty
    a_bufLoad: assert property (p_bufLoad) else $error("holding write did not load counter");

    property p_single;
        s_wrapSingle |=> (cnt_r == '0) && !csr_r.run ##1 (cnt_r == '0 || $past(wrBuf) || $past(maintPulse));
    endproperty
    a_single: assert property (p_single) else $error("single mode did not stop at zero");

    property p_repeat;
        (wrap && csr_r.repeatMode && !wrBuf) |=> (cnt_r == $past(buf_r)) && $stable(buf_r);
    endproperty
    a_repeat: assert property (p_repeat) else $error("repeat mode did not reload");

    property p_error;
        (wrap && csr_r.repeatMode && csr_r.doneFlag) |=> csr_r.errFlag;
    endproperty
    a_error: assert property (p_error) else $error("missed-service error not flagged");

    property p_done;
        wrap |=> csr_r.doneFlag;
    endproperty
    a_done: assert property (p_done) else $error("wrap flag not set");

    property p_intGate;
        $rose(intReq) |-> $past(intSet);
    endproperty
    a_intGate: assert property (p_intGate) else $error("interrupt without enabled wrap");

    property p_intDrop;
        (intReq && intGrant && !intSet) |=> !intReq;
    endproperty
    a_intDrop: assert property (p_intDrop) else $error("request held after grant");

    property p_maint;
        (maintPulse && !wrap) |=> cnt_r == $past(cntStep);
    endproperty
    a_maint: assert property (p_maint) else $error("maintenance step wrong");

    property p_noCntWrite;
        (busAck && avs_write && isReg(avs_address, `PIC_IDX_CNT) && !step) |=> $stable(cnt_r);
    endproperty
    a_noCntWrite: assert property (p_noCntWrite) else $error("counter written by host");

    property p_reset;
        @(posedge ref_clk) disable iff (1'b0)
            sys_rst |=> (cnt_r == '0) && (csr_r == pic_csr_t'(`PIC_CSR_RST)) && !intReq;
    endproperty
    a_reset: assert property (p_reset) else $error("reset did not clear state");

endmodule

// ---- logic/pic_pkg.sv ----
// Types shared by the interval clock modules
package pic_pkg;

    // ------------------------------------------------------------
    // Count source selection
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PIC_RATE_100K = 2'h0,
        PIC_RATE_10K  = 2'h1,
        PIC_RATE_LINE = 2'h2,
        PIC_RATE_EXT  = 2'h3
    } pic_rate_t;

    // ------------------------------------------------------------
    // Bus answer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PIC_BUS_IDLE = 2'h1,
        PIC_BUS_ACK  = 2'h2
    } pic_bus_st_t;

    // ------------------------------------------------------------
    // Control/status word, bit 8 down to bit 0
    // ------------------------------------------------------------
    typedef struct packed {
        logic      errFlag;
        logic      doneFlag;
        logic      intEn;
        logic      maint;
        logic      countDown;
        logic      repeatMode;
        pic_rate_t rate;
        logic      run;
    } pic_csr_t;

endpackage

// ---- logic/pic_regs.svh ----
// Register indices, field positions, reset values and timing of the interval clock
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PIC_IDX_CSR 2'h0
`define PIC_IDX_BUF 2'h1
`define PIC_IDX_CNT 2'h2

// ----------------------------------------------------------------
// Control/status word field positions
// ----------------------------------------------------------------
`define PIC_B_RUN     0
`define PIC_B_RATE_LO 1
`define PIC_B_RATE_HI 2
`define PIC_B_REPEAT  3
`define PIC_B_DOWN    4
`define PIC_B_MAINT   5
`define PIC_B_INTEN   6
`define PIC_B_DONE    7
`define PIC_B_ERR     8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PIC_CSR_RST 9'h000
`define PIC_CNT_RST 16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PIC_CLK_PERIOD_NS  10
`define PIC_BASE_PERIOD_NS 10000
`define PIC_BASE_CYCLES    (`PIC_BASE_PERIOD_NS / `PIC_CLK_PERIOD_NS)
`define PIC_SLOW_PERIOD_NS 100000
`define PIC_SLOW_DIV       (`PIC_SLOW_PERIOD_NS / `PIC_BASE_PERIOD_NS)

`endif

// ---- logic/pic_src_sel.sv ----
// Count source generation, synchronisation and selection
`timescale 1ns/1ps
`include "pic_regs.svh"

module pic_src_sel
    import pic_pkg::*;
#(
    parameter int BASE_CYCLES = `PIC_BASE_CYCLES,
    parameter int SLOW_DIV    = `PIC_SLOW_DIV
) (
    input  wire logic      ref_clk,
    input  wire logic      sys_rst,
    input  wire pic_rate_t rate,
    input  wire logic      lineIn,
    input  wire logic      extIn,
    output logic           srcTick
);

    localparam int BW = $clog2(BASE_CYCLES);
    localparam int SW = $clog2(SLOW_DIV);

    logic [BW-1:0] baseCnt_r;
    logic [SW-1:0] slowCnt_r;
    logic          baseTick;
    logic          slowTick;
    logic [1:0]    pinIn;
    logic [1:0]    meta_r;
    logic [1:0]    sync_r;
    logic [1:0]    prev_r;
    logic [1:0]    pinEdge;
    logic          tick_nxt;
    logic          tick_r;
    pic_rate_t     rate_r;

    // ------------------------------------------------------------
    // Base and divided rates
    // ------------------------------------------------------------
    assign baseTick = (baseCnt_r == BW'(BASE_CYCLES - 1));
    assign slowTick = baseTick & (slowCnt_r == SW'(SLOW_DIV - 1));

    always_ff @(posedge ref_clk) begin
        if (sys_rst || baseTick) begin
            baseCnt_r <= '0;
        end else begin
            baseCnt_r <= baseCnt_r + BW'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || slowTick) begin
            slowCnt_r <= '0;
        end else if (baseTick) begin
            slowCnt_r <= slowCnt_r + SW'(1);
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers with rising-edge detect
    // ------------------------------------------------------------
    assign pinIn = {extIn, lineIn};

    for (genvar g = 0; g < 2; g++) begin : g_pin
        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                meta_r[g] <= 1'b0;
                sync_r[g] <= 1'b0;
                prev_r[g] <= 1'b0;
            end else begin
                meta_r[g] <= pinIn[g];
                sync_r[g] <= meta_r[g];
                prev_r[g] <= sync_r[g];
            end
        end
        assign pinEdge[g] = sync_r[g] & ~prev_r[g];
    end

    // ------------------------------------------------------------
    // Source multiplexer
    // ------------------------------------------------------------
    always_comb begin
        unique case (rate)
            PIC_RATE_100K: tick_nxt = baseTick;
            PIC_RATE_10K:  tick_nxt = slowTick;
            PIC_RATE_LINE: tick_nxt = pinEdge[0];
            PIC_RATE_EXT:  tick_nxt = pinEdge[1];
        endcase
    end

    // Tick registered with the select; a tick of the old source is dropped
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tick_r <= 1'b0;
            rate_r <= PIC_RATE_100K;
        end else begin
            tick_r <= tick_nxt;
            rate_r <= rate;
        end
    end

    assign srcTick = tick_r & (rate == rate_r);

    property p_slowSpacing;
        @(posedge ref_clk) disable iff (sys_rst) slowTick |-> baseTick ##1 !slowTick [*8];
    endproperty
    a_slowSpacing: assert property (p_slowSpacing) else $error("slow rate not derived from base");

    property p_tickSingle;
        @(posedge ref_clk) disable iff (sys_rst) srcTick |=> !srcTick;
    endproperty
    a_tickSingle: assert property (p_tickSingle) else $error("count enable wider than one cycle");

endmodule

// ---- tb/pic_arbiter_model.sv ----
// Bus arbiter model that grants interrupt requests after a set wait
`timescale 1ns/1ps

module pic_arbiter_model (
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       intReq,
    input  wire logic [7:0] grantDelay,
    output logic            intGrant
);
    logic [7:0] waitCnt_r;

    // One-cycle grant once the request has waited long enough
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !intReq || intGrant) begin
            waitCnt_r <= 8'h00;
            intGrant  <= 1'b0;
        end else if (waitCnt_r == grantDelay) begin
            intGrant <= 1'b1;
        end else begin
            waitCnt_r <= waitCnt_r + 8'h01;
        end
    end
endmodule

// ---- tb/pic_interval_clock_bench.sv ----
// Self-checking bench for the interval clock register slave
`timescale 1ns/1ps

module pic_interval_clock_bench
    import pic_pkg::*;
();
    localparam int BASE  = 8;
    localparam int SLOW  = 2;
    localparam int LIMIT = 20000;

    logic        ref_clk;
    logic        sys_rst       = 1'b1;
    logic [3:0]  avs_address   = 4'h0;
    logic        avs_read      = 1'b0;
    logic        avs_write     = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        lineIn        = 1'b0;
    logic        extIn         = 1'b0;
    logic        intReq;
    logic        intGrant;
    logic [7:0]  grantDelay    = 8'h01;
    logic        lastReq       = 1'b0;
    logic [31:0] q;
    logic [31:0] q2;
    int          n_fail        = 0;
    int          n_checks      = 0;
    int          cyc           = 0;
    int          nRise         = 0;
    int          riseAt        = 0;
    int          prevRise      = 0;

    pic_interval_clock #(.BASE_CYCLES(BASE), .SLOW_DIV(SLOW)) DUT (
        .ref_clk        (ref_clk),
        .sys_rst        (sys_rst),
        .avs_address    (avs_address),
        .avs_read       (avs_read),
        .avs_write      (avs_write),
        .avs_writedata  (avs_writedata),
        .avs_readdata   (avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .lineIn         (lineIn),
        .extIn          (extIn),
        .intReq         (intReq),
        .intGrant       (intGrant)
    );

    pic_arbiter_model arbiter (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .intReq    (intReq),
        .grantDelay(grantDelay),
        .intGrant  (intGrant)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Interrupt rise times and overall cycle ceiling
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        lastReq <= intReq;
        if (intReq === 1'b1 && lastReq === 1'b0) begin
            prevRise <= riseAt;
            riseAt <= cyc;
            nRise <= nRise + 1;
        end
        if (cyc == LIMIT) begin
            n_fail = n_fail + 1;
            complete_run();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [3:0] a);
        bus(1'b0, a, 32'h00000000);
    endtask

    function automatic logic [31:0] mk(pic_rate_t r, logic rp, logic dn, logic ie, logic mt, logic rn);
        pic_csr_t c;
        c = '{1'b0, 1'b0, ie, mt, dn, rp, r, rn};
        return {23'h0, c};
    endfunction

    task automatic waitRise(input int target);
        int n;
        n = 0;
        while (nRise < target && n < 1000) begin
            @(posedge ref_clk);
            n++;
        end
    endtask

    task automatic pulse(input logic ext);
        if (ext) extIn <= 1'b1;
        else lineIn <= 1'b1;
        idle(3);
        extIn <= 1'b0;
        lineIn <= 1'b0;
        idle(3);
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        idle(4);
        sys_rst <= 1'b0;
        idle(1);
        rd(4'h0); chk("csr reset", q, 32'h00000000);
        rd(4'h8); chk("counter reset", q, 32'h00000000);
        wr(4'h4, 32'h00000007);
        rd(4'h4); chk("holding read", q, 32'h00000000);
        rd(4'h8); chk("counter load", q, 32'h00000007);
        wr(4'h8, 32'h00001234);
        rd(4'hA); chk("counter unwritable", q, 32'h00000007);
        rd(4'hC); chk("unmapped read", q, 32'h00000000);
        wr(4'h0, mk(PIC_RATE_100K, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0));
        rd(4'h8); chk("step down", q, 32'h00000006);
        wr(4'h0, mk(PIC_RATE_100K, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0));
        rd(4'h8); chk("step up", q, 32'h00000007);
        rd(4'h0); chk("maint reads zero", q, 32'h00000000);
        // Single mode, counting down with interrupt
        wr(4'h4, 32'h00000002);
        wr(4'h0, mk(PIC_RATE_100K, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1));
        waitRise(1); chk("single irq", 32'(nRise), 32'h00000001);
        idle(20);
        rd(4'h8); chk("single stops at zero", q, 32'h00000000);
        rd(4'h0); chk("single csr", q, mk(PIC_RATE_100K, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0) | 32'h00000080);
        chk("grant drops request", 32'(intReq), 32'h00000000);
        // Overflow counting up, interrupt disabled
        wr(4'h0, 32'h00000080);
        wr(4'h4, 32'h0000FFFE);
        wr(4'h0, mk(PIC_RATE_100K, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
        idle(40);
        rd(4'h8); chk("overflow counter", q, 32'h00000000);
        rd(4'h0); chk("overflow flag", q, 32'h00000080);
        chk("no irq when disabled", 32'(nRise), 32'h00000001);
        // Repeat mode at the slow rate with a slow arbiter
        grantDelay <= 8'h0A;
        wr(4'h0, 32'h00000080);
        wr(4'h4, 32'h00000003);
        wr(4'h0, mk(PIC_RATE_10K, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1));
        waitRise(3);
        chk("repeat period", 32'(riseAt - prevRise), 32'(3 * BASE * SLOW));
        rd(4'h0); chk("overrun error", 32'(q[8]), 32'h00000001);
        rd(4'h8);
        q2 = q;
        idle(17);
        rd(4'h8); chk("live read moves", 32'(q !== q2), 32'h00000001);
        chk("reload not zero", 32'(q == 32'h00000000), 32'h00000000);
        wr(4'h0, 32'h00000000);
        wr(4'h0, 32'h00000180);
        rd(4'h0); chk("flags cleared", q, 32'h00000000);
        // Line and external sources
        wr(4'h4, 32'h00000000);
        wr(4'h0, mk(PIC_RATE_LINE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
        for (int i = 0; i < 3; i++) pulse(1'b0);
        pulse(1'b1);
        idle(6);
        rd(4'h8); chk("line count", q, 32'h00000003);
        wr(4'h4, 32'h00000005);
        wr(4'h0, mk(PIC_RATE_EXT, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1));
        for (int i = 0; i < 2; i++) pulse(1'b1);
        pulse(1'b0);
        idle(6);
        rd(4'h8); chk("event count", q, 32'h00000003);
        complete_run();
    end
endmodule
